// [slpsd_top.sv]
// Serial load power shift driver: shift stage, storage stage, gated switch drive.
// Assumes host pins are asynchronous; switches are open-drain, enable high sinks.
`timescale 1ns/10ps
module slpsd_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic shift_clock_in,
  input wire logic latch_clock_in,
  input wire logic clear_all_n_in,
  input wire logic out_enable_n_in,
  input wire logic shift_data_input_in,
  input wire logic load_ready_in,
  output logic latch_ready_out,
  output logic chain_data_output_out,
  output logic [7:0] load_switch_outputs_out,
  output logic [7:0] load_switch_outputs_en_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    slpsd_pkg::slpsd_pins_s prev;
    slpsd_pkg::slpsd_word_t shift;
    slpsd_pkg::slpsd_word_t storage;
    slpsd_pkg::slpsd_word_t drive;
    logic chain;
  } slpsd_top_s;

  slpsd_top_s state;
  slpsd_top_s next_state;
  slpsd_pkg::slpsd_pins_s pins_raw;
  slpsd_pkg::slpsd_pins_s pins;
  logic shift_rise;
  logic shift_fall;
  logic latch_rise;
  logic clr_active;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  slpsd_pkg::slpsd_word_t buf_out_data;

  // ---------------------------------------------------------------
  // Pin capture
  // ---------------------------------------------------------------
  always_comb begin
    pins_raw.shift_clock = shift_clock_in;
    pins_raw.latch_clock = latch_clock_in;
    pins_raw.clear_all_n = clear_all_n_in;
    pins_raw.out_enable_n = out_enable_n_in;
    pins_raw.shift_data_input = shift_data_input_in;
  end

  slpsd_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in(pins_raw),
    .pins_out(pins)
  );

  assign shift_rise = pins.shift_clock && !state.prev.shift_clock;
  assign shift_fall = !pins.shift_clock && state.prev.shift_clock;
  assign latch_rise = pins.latch_clock && !state.prev.latch_clock;
  assign clr_active = !pins.clear_all_n;

  // ---------------------------------------------------------------
  // Latched words wait here until the output stage takes them
  // ---------------------------------------------------------------
  slpsd_buf u_buf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in(clr_active),
    .in_valid_in(latch_rise && !clr_active),
    .in_data_in(state.shift),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(load_ready_in)
  );

  assign buf_pop = buf_out_valid && load_ready_in && !clr_active;
  assign latch_ready_out = buf_in_ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.prev = pins;
    if (clr_active) begin
      next_state.shift = slpsd_pkg::WORD_ZERO;
      next_state.storage = slpsd_pkg::WORD_ZERO;
    end else begin
      if (shift_rise) begin
        next_state.shift = {state.shift[slpsd_pkg::LAST_BIT-1:0], pins.shift_data_input};
      end
      if (buf_pop) begin
        next_state.storage = buf_out_data;
      end
    end
    if (shift_fall) begin
      next_state.chain = state.shift[slpsd_pkg::LAST_BIT];
    end
    if (pins.out_enable_n || clr_active) begin
      next_state.drive = slpsd_pkg::WORD_ZERO;
    end else begin
      next_state.drive = state.storage;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '{prev: slpsd_pkg::PINS_RST, shift: slpsd_pkg::WORD_ZERO,
                 storage: slpsd_pkg::WORD_ZERO, drive: slpsd_pkg::WORD_ZERO, chain: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Open-drain switches: pin level held low, enable sinks current
  // ---------------------------------------------------------------
  assign load_switch_outputs_out = slpsd_pkg::WORD_ZERO;
  assign load_switch_outputs_en_out = state.drive;
  assign chain_data_output_out = state.chain;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_shift_advance: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    shift_rise && !clr_active |=> state.shift == {$past(state.shift[6:0]),
                                                  $past(pins.shift_data_input)})
    else $error("shift register did not advance");

  chk_shift_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !shift_rise && !clr_active |=> $stable(state.shift))
    else $error("shift register moved without a shift edge");

  chk_clear_regs: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clr_active |=> state.shift == 8'h00 && state.storage == 8'h00)
    else $error("clear left data in registers");

  chk_clear_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clr_active |=> load_switch_outputs_en_out == 8'h00)
    else $error("switches on during clear");

  chk_disable_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pins.out_enable_n |=> load_switch_outputs_en_out == 8'h00)
    else $error("switches on while disabled");

  chk_enable_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !pins.out_enable_n && !clr_active |=> load_switch_outputs_en_out == $past(state.storage))
    else $error("switches do not follow storage");

  chk_latch_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    buf_pop |=> state.storage == $past(buf_out_data))
    else $error("storage missed a latched word");

  chk_chain_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    shift_fall |=> chain_data_output_out == $past(state.shift[7]))
    else $error("chain output not taken on falling edge");

  chk_chain_still: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !shift_fall |=> $stable(chain_data_output_out))
    else $error("chain output changed off a falling edge");

  chk_pin_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 load_switch_outputs_out == 8'h00)
    else $error("switch pin level not held low");

endmodule // slpsd_top

// [slpsd_pkg.sv]
// Constants and carrier types of the serial load power shift driver.
// Assumes one 25 MHz system clock; all pin inputs are asynchronous to it.
//
// Functional notes
// - An 8-bit serial-in shift register feeds an 8-bit storage register of the same width.
// - The shift register moves one place per rising shift clock; a rising latch clock queues the word in the two-entry buffer, and storage loads when it is popped.
// - Stored data reaches the output buffer only while the clear input is high.
// - A low clear input empties both the shift register and the storage register.
// - A high output enable forces every output buffer bit low so all switches are off.
// - A low output enable lets the buffer follow the storage register without further clocking.
// - The chain output changes on the falling shift clock edge, giving the next device extra hold time.
// - A switch is off for a buffer bit of 0 and sinks load current for a bit of 1.
package slpsd_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 8;
  localparam int unsigned LAST_BIT = 7;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [7:0] WORD_ZERO = 8'h00;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_FULL = 2'h2;

  typedef logic [WORD_W-1:0] slpsd_word_t;

  // Pin group as sampled from the host
  typedef struct packed {
    logic shift_clock;
    logic latch_clock;
    logic clear_all_n;
    logic out_enable_n;
    logic shift_data_input;
  } slpsd_pins_s;

  // Safe pin values while in reset: cleared, outputs disabled
  localparam slpsd_pins_s PINS_RST = '{
    shift_clock: 1'b0,
    latch_clock: 1'b0,
    clear_all_n: 1'b0,
    out_enable_n: 1'b1,
    shift_data_input: 1'b0
  };

endpackage

// [slpsd_sync.sv]
// Two-flop synchroniser for the host pin group.
// Assumes pins are asynchronous to clk_in; only the second stage is read.
`timescale 1ns/10ps
module slpsd_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input slpsd_pkg::slpsd_pins_s pins_in,
  output slpsd_pkg::slpsd_pins_s pins_out
);

  typedef struct packed {
    slpsd_pkg::slpsd_pins_s stage1;
    slpsd_pkg::slpsd_pins_s stage2;
  } slpsd_sync_s;

  slpsd_sync_s state;
  slpsd_sync_s next_state;

  always_comb begin
    next_state = state;
    next_state.stage1 = pins_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '{stage1: slpsd_pkg::PINS_RST, stage2: slpsd_pkg::PINS_RST};
    end else begin
      state <= next_state;
    end
  end

  assign pins_out = state.stage2;

endmodule // slpsd_sync

// [slpsd_buf.sv]
// Two-entry word buffer with valid and ready on both sides.
// Assumes flush comes from logic on clk_in; flush wins over a push.
`timescale 1ns/10ps
module slpsd_buf (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input slpsd_pkg::slpsd_word_t in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output slpsd_pkg::slpsd_word_t out_data_out,
  input wire logic out_ready_in
);

  typedef struct packed {
    slpsd_pkg::slpsd_word_t [slpsd_pkg::BUF_DEPTH-1:0] mem;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] count;
  } slpsd_buf_s;

  slpsd_buf_s state;
  slpsd_buf_s next_state;
  logic push;
  logic pop;

  assign in_ready_out = (state.count != slpsd_pkg::CNT_FULL);
  assign out_valid_out = (state.count != slpsd_pkg::CNT_ZERO);
  assign out_data_out = state.mem[state.rd_idx];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    next_state = state;
    if (flush_in) begin
      next_state.wr_idx = 1'b0;
      next_state.rd_idx = 1'b0;
      next_state.count = slpsd_pkg::CNT_ZERO;
    end else begin
      if (push) begin
        next_state.mem[state.wr_idx] = in_data_in;
        next_state.wr_idx = ~state.wr_idx;
      end
      if (pop) begin
        next_state.rd_idx = ~state.rd_idx;
      end
      next_state.count = state.count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  chk_buf_no_overrun: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state.count <= slpsd_pkg::CNT_FULL)
    else $error("buffer count above depth");

endmodule // slpsd_buf

// [slpsd_host.sv]
// Host model: drives shift clock, latch clock and serial data pins.
// Assumes clk_in is the 25 MHz bench clock; pin phases last 4 cycles.
`timescale 1ns/10ps
module slpsd_host (
  input wire logic clk_in,
  output logic shift_clock_out,
  output logic latch_clock_out,
  output logic shift_data_input_out
);
  // ---------------------------------------------------------------
  // Pin sequencing
  // ---------------------------------------------------------------
  initial begin
    shift_clock_out = 1'b0;
    latch_clock_out = 1'b0;
    shift_data_input_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One bit: data set before the rise, clock left high
  task automatic rise_bit(input logic b);
    shift_data_input_out = b;
    step(4);
    shift_clock_out = 1'b1;
    step(4);
  endtask

  // Clock low; data no longer valid, so show the inverse
  task automatic fall_bit();
    shift_clock_out = 1'b0;
    shift_data_input_out = ~shift_data_input_out;
    step(4);
  endtask

  // MSB first, eight bits then stop
  task automatic shift_word(input slpsd_pkg::slpsd_word_t w);
    for (int i = 7; i >= 0; i--) begin
      rise_bit(w[i]);
      fall_bit();
    end
  endtask

  task automatic latch_word();
    latch_clock_out = 1'b1;
    step(4);
    latch_clock_out = 1'b0;
    step(4);
  endtask
endmodule // slpsd_host

// [slpsd_tb.sv]
// Self-checking bench for the serial load power shift driver.
// Assumes the host model drives the serial pins; other inputs driven here.
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] word;
    logic oe_n;
    logic clr_n;
    logic chain;
    logic [7:0] exp;
  } slpsd_row_s;

  logic clk_in;
  logic sys_rst_in;
  logic shift_clock_in;
  logic latch_clock_in;
  logic clear_all_n_in;
  logic out_enable_n_in;
  logic shift_data_input_in;
  logic load_ready_in;
  logic latch_ready_out;
  logic chain_data_output_out;
  logic [7:0] load_switch_outputs_out;
  logic [7:0] load_switch_outputs_en_out;
  int n_errors;
  int checked;
  slpsd_row_s rows [5];

  slpsd_top DUT (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .shift_clock_in(shift_clock_in),
    .latch_clock_in(latch_clock_in),
    .clear_all_n_in(clear_all_n_in),
    .out_enable_n_in(out_enable_n_in),
    .shift_data_input_in(shift_data_input_in),
    .load_ready_in(load_ready_in),
    .latch_ready_out(latch_ready_out),
    .chain_data_output_out(chain_data_output_out),
    .load_switch_outputs_out(load_switch_outputs_out),
    .load_switch_outputs_en_out(load_switch_outputs_en_out)
  );

  slpsd_host host (
    .clk_in(clk_in),
    .shift_clock_out(shift_clock_in),
    .latch_clock_out(latch_clock_in),
    .shift_data_input_out(shift_data_input_in)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and checking
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    report_and_stop();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic load(input logic [7:0] w);
    host.shift_word(w);
    host.latch_word();
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    sys_rst_in = 1'b1;
    clear_all_n_in = 1'b0;
    out_enable_n_in = 1'b1;
    load_ready_in = 1'b1;
    rows = '{'{8'hA5, 1'b0, 1'b1, 1'b1, 8'hA5}, '{8'h3C, 1'b1, 1'b1, 1'b0, 8'h00},
             '{8'hC3, 1'b0, 1'b0, 1'b0, 8'h00}, '{8'hFF, 1'b0, 1'b1, 1'b1, 8'hFF},
             '{8'h5A, 1'b0, 1'b1, 1'b0, 8'h5A}};
    host.step(10);
    check(load_switch_outputs_en_out, 8'h00, "drive in reset");
    check({7'h00, latch_ready_out}, 8'h01, "ready in reset");
    host.step(10);
    sys_rst_in = 1'b0;
    clear_all_n_in = 1'b1;
    host.step(5);
    foreach (rows[i]) begin
      out_enable_n_in = rows[i].oe_n;
      clear_all_n_in = rows[i].clr_n;
      host.shift_word(rows[i].word);
      check({7'h00, chain_data_output_out}, {7'h00, rows[i].chain}, "chain");
      host.latch_word();
      host.step(10);
      check(load_switch_outputs_en_out, rows[i].exp, "drive");
      check(load_switch_outputs_out, 8'h00, "pin level");
    end
    // Enable toggled with no clocking
    out_enable_n_in = 1'b1;
    host.step(6);
    check(load_switch_outputs_en_out, 8'h00, "enable off");
    out_enable_n_in = 1'b0;
    host.step(6);
    check(load_switch_outputs_en_out, 8'h5A, "enable on");
    // Clear empties both registers
    clear_all_n_in = 1'b0;
    host.step(6);
    check(load_switch_outputs_en_out, 8'h00, "clear drive");
    clear_all_n_in = 1'b1;
    host.step(6);
    check(load_switch_outputs_en_out, 8'h00, "storage cleared");
    host.latch_word();
    host.step(10);
    check(load_switch_outputs_en_out, 8'h00, "shift cleared");
    // Buffer filled while output stage stalls, third latch dropped
    load_ready_in = 1'b0;
    load(8'hC3);
    load(8'h96);
    check({7'h00, latch_ready_out}, 8'h00, "buffer full");
    check(load_switch_outputs_en_out, 8'h00, "stalled");
    load(8'h0F);
    load_ready_in = 1'b1;
    host.step(12);
    check(load_switch_outputs_en_out, 8'h96, "drained");
    check({7'h00, latch_ready_out}, 8'h01, "buffer empty");
    // Chain output follows the falling edge only
    host.shift_word(8'h80);
    check({7'h00, chain_data_output_out}, 8'h01, "chain last stage");
    // Rise alone leaves the chain output alone; the fall moves it
    host.rise_bit(1'b0);
    check({7'h00, chain_data_output_out}, 8'h01, "chain held on rise");
    host.fall_bit();
    check({7'h00, chain_data_output_out}, 8'h00, "chain on fall");
    report_and_stop();
  end
endmodule // tb
